// ---- oam_endpoint_pkg.sv ----
// Package for the OAM endpoint frame engine: opcodes, widths, reset values.
// Assumes a single core clock; shared by the engine and the bench.
package oam_endpoint_pkg;
  localparam int DATA_W = 96;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 32;
  localparam int SEQ_W = 32;
  localparam int NUM_SETS = 32;
  localparam int NUM_SHARED_COS = 7;
  localparam logic [2:0] COS_OWN = 3'h7;
  localparam logic [7:0] OP_CCM = 8'h01;
  localparam logic [7:0] OP_LBR = 8'h02;
  localparam logic [7:0] OP_LBM = 8'h03;
  localparam logic [7:0] OP_LMR = 8'h2A;
  localparam logic [7:0] OP_LMM = 8'h2B;
  localparam logic [7:0] OP_DMR = 8'h2E;
  localparam logic [7:0] OP_DMM = 8'h2F;
  localparam logic [7:0] OP_SLR = 8'h36;
  localparam logic [7:0] OP_SLM = 8'h37;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic [SEQ_W-1:0] SEQ_RST = 32'h0000_0000;
  localparam logic [SEQ_W-1:0] SEQ_STEP = 32'h0000_0001;
  // Loop kinds, index into loop enable vector.
  localparam int LOOP_LB = 0;
  localparam int LOOP_LM = 1;
  localparam int LOOP_DM = 2;
  localparam int LOOP_SL = 3;
  localparam int LOOP_CUSTOM = 4;
  localparam int NUM_LOOP = 5;
  // Result FIFO word layout.
  localparam int F_SMAC_LO = 0;
  localparam int F_DMAC_LO = 48;
  typedef enum logic [1:0] {PATH_NORMAL, PATH_EGRESS_SRC, PATH_INGRESS_HOME, PATH_DROP} path_t;
endpackage

// ---- oam_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides; read data comes straight from the storage array.
// Assumes writer and reader on the same clock.
`timescale 1ns/10ps
module oam_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Output word is read combinationally from the array at rd_q; pop happens only on valid and ready.
  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // Storage without reset keeps the array cheap.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- oam_endpoint_frame_engine.sv ----
// Per-endpoint OAM frame engine: blocking, looping, counters, sequence numbering.
// Assumes one frame descriptor per cycle from the switch pipeline, same clock.
// Notes on behaviour
// - Data blocking passes only valid OAM PDUs.
// - Blocked frames count per direction.
// - Enabled messages are looped into responses.
// - Opcode 3 to 2, 43 to 42.
// - Opcode 47 to 46, 55 to 54.
// - Response DMAC is message SMAC; SMAC unicast.
// - Down side loops to egress of source.
// - Up side loops to ingress of home port.
// - Replace service index, optional DP clear, rewrite.
// - Disabled endpoint does no validation or processing.
// - Level value filters both directions.
// - One bit selects up or down side.
// - DMAC check against multicast or unicast.
// - Selected and non-selected counters per direction.
// - Common numbering; per-class uses shared sets.
// - Per-class updates assigned set, classes 0-6.
// - CCM-LM needs both enables and nonzero counter.
// - CCM disabled leaves CCM unmodified.
// - CCM counting gated by separate enables.
// - Tx CCM carries stored sequence, always increments.
// - Tx CCM defect field overwritten.
`timescale 1ns/10ps
module oam_endpoint_frame_engine
  import oam_endpoint_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic endpoint_enable,
  input wire logic [2:0] maint_level_value,
  input wire logic up_side_select,
  input wire logic rx_dest_mac_check_select,
  input wire logic [47:0] uc_mac,
  input wire logic [47:0] mc_mac,
  input wire logic block_data_rx,
  input wire logic block_data_tx,
  input wire logic [NUM_LOOP-1:0] loop_en,
  input wire logic [7:0] custom_message,
  input wire logic [7:0] custom_response,
  input wire logic [11:0] loop_service_index,
  input wire logic loop_drop_prec_clear,
  input wire logic loop_egress_rewrite_index_en,
  input wire logic [255:0] pdu_selected,
  input wire logic continuity_hw_en,
  input wire logic continuity_loss_hw_en,
  input wire logic continuity_pdu_count_en,
  input wire logic continuity_loss_pdu_count_en,
  input wire logic continuity_in_loss_counters_en,
  input wire logic tx_seq_overwrite_en,
  input wire logic tx_remote_defect_value,
  input wire logic per_class_seq_loopback_en,
  input wire logic per_class_seq_continuity_en,
  input wire logic [4:0] per_class_counter_set_sel,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_tx,
  input wire logic in_is_oam,
  input wire logic [7:0] in_opcode,
  input wire logic [2:0] in_level,
  input wire logic [47:0] in_dmac,
  input wire logic [47:0] in_smac,
  input wire logic [2:0] class_of_service_id,
  input wire logic in_lm_nonzero,
  input wire logic [11:0] in_service_index,
  input wire logic in_drop_prec,
  input wire logic [5:0] in_port,
  input wire logic [5:0] home_port,
  output logic out_valid,
  input wire logic out_ready,
  output logic [47:0] out_dmac,
  output logic [47:0] out_smac,
  output logic [7:0] out_opcode,
  output logic [11:0] out_service_index,
  output logic out_drop_prec,
  output logic out_rewrite_index_en,
  output logic [5:0] out_port,
  output logic [1:0] out_path,
  output logic out_seq_write,
  output logic [SEQ_W-1:0] out_seq,
  output logic out_rdi_write,
  output logic out_rdi,
  output logic loss_counter_inc,
  output logic [CNT_W-1:0] rx_drop_count,
  output logic [CNT_W-1:0] tx_drop_count,
  output logic [CNT_W-1:0] rx_sel_count,
  output logic [CNT_W-1:0] rx_nonsel_count,
  output logic [CNT_W-1:0] tx_sel_count,
  output logic [CNT_W-1:0] tx_nonsel_count,
  output logic [SEQ_W-1:0] tx_seq_value
);
  // One-hot loop kind of an opcode; the custom message has a bit of its own.
  function automatic logic [NUM_LOOP:0] loop_kind(input logic [7:0] op, input logic [7:0] cmsg);
    logic [NUM_LOOP:0] k;
    k = '0;
    k[LOOP_LB] = (op == OP_LBM);
    k[LOOP_LM] = (op == OP_LMM);
    k[LOOP_DM] = (op == OP_DMM);
    k[LOOP_SL] = (op == OP_SLM);
    k[LOOP_CUSTOM] = (op == cmsg);
    return k;
  endfunction

  localparam int WORD_W = 48 + 48 + 8 + 12 + 1 + 1 + 6 + 2 + 1 + SEQ_W + 1 + 1 + 1;

  logic [NUM_LOOP:0] kind;
  logic level_ok;
  logic dmac_ok;
  logic valid_oam;
  logic is_ccm;
  logic is_ccm_lm;
  logic do_loop;
  logic drop;
  logic count_pdu;
  logic take;
  logic fifo_ready;
  logic [7:0] resp_op;
  logic per_class;
  logic [SEQ_W-1:0] seq_use;
  logic [SEQ_W-1:0] shared_seq_q [NUM_SETS][NUM_SHARED_COS];
  logic [SEQ_W-1:0] tx_seq_q;
  logic [CNT_W-1:0] rx_drop_q;
  logic [CNT_W-1:0] tx_drop_q;
  logic [CNT_W-1:0] rx_sel_q;
  logic [CNT_W-1:0] rx_non_q;
  logic [CNT_W-1:0] tx_sel_q;
  logic [CNT_W-1:0] tx_non_q;
  logic [WORD_W-1:0] word_d;
  logic [WORD_W-1:0] word_q;
  path_t path;

  // Classification of the descriptor at the input.
  assign kind = loop_kind(in_opcode, custom_message);
  assign level_ok = (in_level == maint_level_value);
  assign dmac_ok = in_tx || (in_dmac == (rx_dest_mac_check_select ? uc_mac : mc_mac));
  assign valid_oam = in_is_oam && level_ok && dmac_ok;
  assign is_ccm = valid_oam && (in_opcode == OP_CCM);
  assign is_ccm_lm = is_ccm && continuity_hw_en && continuity_loss_hw_en && in_lm_nonzero;
  assign do_loop = endpoint_enable && !in_tx && valid_oam && |(kind[NUM_LOOP-1:0] & loop_en);
  // A disabled endpoint lets everything through untouched.
  assign drop = endpoint_enable && !valid_oam && (in_tx ? block_data_tx : block_data_rx);
  assign count_pdu = endpoint_enable && valid_oam &&
    (!is_ccm || (is_ccm_lm ? continuity_loss_pdu_count_en : continuity_pdu_count_en));
  // Drops travel through the FIFO as well, so order is kept at the cost of a slot each.
  assign in_ready = fifo_ready;
  assign take = in_valid && in_ready;

  // Opcode rewrite for looped responses.
  always_comb begin
    resp_op = in_opcode;
    if (kind[LOOP_LB]) begin
      resp_op = OP_LBR;
    end else if (kind[LOOP_LM]) begin
      resp_op = OP_LMR;
    end else if (kind[LOOP_DM]) begin
      resp_op = OP_DMR;
    end else if (kind[LOOP_SL]) begin
      resp_op = OP_SLR;
    end else if (kind[LOOP_CUSTOM]) begin
      resp_op = custom_response;
    end
  end

  // Placement of the response depends on the side bit.
  always_comb begin
    if (drop) begin
      path = PATH_DROP;
    end else if (do_loop) begin
      path = up_side_select ? PATH_INGRESS_HOME : PATH_EGRESS_SRC;
    end else begin
      path = PATH_NORMAL;
    end
  end

  // Sequence source: own state for class 7 or common mode, shared set otherwise.
  assign per_class = per_class_seq_continuity_en || per_class_seq_loopback_en;
  assign seq_use = (per_class_seq_continuity_en && class_of_service_id != COS_OWN) ?
    shared_seq_q[per_class_counter_set_sel][class_of_service_id] : tx_seq_q;

  // Build the outgoing word.
  always_comb begin
    word_d = '0;
    word_d[F_SMAC_LO +: 48] = do_loop ? uc_mac : in_smac;
    word_d[F_DMAC_LO +: 48] = do_loop ? in_smac : in_dmac;
    word_d[96 +: 8] = do_loop ? resp_op : in_opcode;
    word_d[104 +: 12] = do_loop ? loop_service_index : in_service_index;
    word_d[116] = (do_loop && loop_drop_prec_clear) ? 1'b0 : in_drop_prec;
    word_d[117] = do_loop && loop_egress_rewrite_index_en;
    word_d[118 +: 6] = (do_loop && up_side_select) ? home_port : in_port;
    word_d[124 +: 2] = path;
    // CCM left alone when hardware processing is off.
    word_d[126] = endpoint_enable && in_tx && is_ccm && continuity_hw_en && tx_seq_overwrite_en;
    word_d[127 +: SEQ_W] = seq_use;
    word_d[127 + SEQ_W] = endpoint_enable && in_tx && is_ccm && continuity_hw_en;
    word_d[128 + SEQ_W] = tx_remote_defect_value;
    word_d[129 + SEQ_W] = endpoint_enable && is_ccm && continuity_in_loss_counters_en;
  end

  // Descriptors wait in the FIFO; the pipeline stalls when it fills.
  oam_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(in_valid),
    .in_ready(fifo_ready),
    .in_data(word_d),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(word_q)
  );

  // Unpack the FIFO head.
  assign out_smac = word_q[F_SMAC_LO +: 48];
  assign out_dmac = word_q[F_DMAC_LO +: 48];
  assign out_opcode = word_q[96 +: 8];
  assign out_service_index = word_q[104 +: 12];
  assign out_drop_prec = word_q[116];
  assign out_rewrite_index_en = word_q[117];
  assign out_port = word_q[118 +: 6];
  assign out_path = word_q[124 +: 2];
  assign out_seq_write = word_q[126];
  assign out_seq = word_q[127 +: SEQ_W];
  assign out_rdi_write = word_q[127 + SEQ_W];
  assign out_rdi = word_q[128 + SEQ_W];
  assign loss_counter_inc = out_valid && word_q[129 + SEQ_W];

  // Drop counters, one step per blocked frame.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_drop_q <= CNT_RST;
      tx_drop_q <= CNT_RST;
    end else if (take && drop) begin
      if (in_tx) begin
        tx_drop_q <= tx_drop_q + 1'b1;
      end else begin
        rx_drop_q <= rx_drop_q + 1'b1;
      end
    end
  end

  // PDU counters split by selection and direction.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_sel_q <= CNT_RST;
      rx_non_q <= CNT_RST;
      tx_sel_q <= CNT_RST;
      tx_non_q <= CNT_RST;
    end else if (take && count_pdu) begin
      unique case ({in_tx, pdu_selected[in_opcode]})
        2'b00: rx_non_q <= rx_non_q + 1'b1;
        2'b01: rx_sel_q <= rx_sel_q + 1'b1;
        2'b10: tx_non_q <= tx_non_q + 1'b1;
        2'b11: tx_sel_q <= tx_sel_q + 1'b1;
      endcase
    end
  end

  // Own transmit sequence advances on every processed transmitted CCM not taken by a shared class 0 to 6, overwrite or not.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_seq_q <= SEQ_RST;
    end else if (take && endpoint_enable && in_tx && is_ccm && continuity_hw_en &&
                 !(per_class_seq_continuity_en && class_of_service_id != COS_OWN)) begin
      tx_seq_q <= tx_seq_q + SEQ_STEP;
    end
  end

  // Shared per-class sets: only the assigned set, classes 0 to 6, moves.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        for (int c = 0; c < NUM_SHARED_COS; c++) begin
          shared_seq_q[s][c] <= SEQ_RST;
        end
      end
    end else if (take && endpoint_enable && per_class && in_tx && valid_oam && !drop &&
                 class_of_service_id != COS_OWN) begin
      shared_seq_q[per_class_counter_set_sel][class_of_service_id] <=
        shared_seq_q[per_class_counter_set_sel][class_of_service_id] + SEQ_STEP;
    end
  end

  assign rx_drop_count = rx_drop_q;
  assign tx_drop_count = tx_drop_q;
  assign rx_sel_count = rx_sel_q;
  assign rx_nonsel_count = rx_non_q;
  assign tx_sel_count = tx_sel_q;
  assign tx_nonsel_count = tx_non_q;
  assign tx_seq_value = tx_seq_q;

  // Checks kept beside the logic.
  AST_DROP_RX: assert property (@(posedge clk) disable iff (!resetn)
    (take && drop && !in_tx) |=> (rx_drop_q == $past(rx_drop_q) + 1'b1))
    else $error("rx drop not counted");
  AST_DROP_TX: assert property (@(posedge clk) disable iff (!resetn)
    (take && drop && in_tx) |=> (tx_drop_q == $past(tx_drop_q) + 1'b1) && $stable(rx_drop_q))
    else $error("tx drop not counted");
  AST_BLOCK: assert property (@(posedge clk) disable iff (!resetn)
    (endpoint_enable && !in_tx && block_data_rx && !in_is_oam) |-> path == PATH_DROP)
    else $error("data frame not blocked");
  AST_DISABLED: assert property (@(posedge clk) disable iff (!resetn)
    !endpoint_enable |-> (path == PATH_NORMAL && word_d[126] == 1'b0))
    else $error("disabled endpoint processed frame");
  AST_LBM: assert property (@(posedge clk) disable iff (!resetn)
    (do_loop && in_opcode == OP_LBM) |-> word_d[96 +: 8] == OP_LBR)
    else $error("bad loopback opcode");
  AST_SLM: assert property (@(posedge clk) disable iff (!resetn)
    (do_loop && in_opcode == OP_SLM) |-> word_d[96 +: 8] == OP_SLR)
    else $error("bad synthetic loss opcode");
  AST_SWAP: assert property (@(posedge clk) disable iff (!resetn)
    do_loop |-> (word_d[F_DMAC_LO +: 48] == in_smac && word_d[F_SMAC_LO +: 48] == uc_mac))
    else $error("mac swap wrong");
  AST_SIDE: assert property (@(posedge clk) disable iff (!resetn)
    (do_loop && up_side_select) |-> (path == PATH_INGRESS_HOME && word_d[118 +: 6] == home_port))
    else $error("up side placement wrong");
  AST_SEQ: assert property (@(posedge clk) disable iff (!resetn)
    (take && endpoint_enable && in_tx && is_ccm && continuity_hw_en && !per_class_seq_continuity_en)
    |=> tx_seq_q == $past(tx_seq_q) + SEQ_STEP)
    else $error("tx sequence not advanced");
  AST_LM: assert property (@(posedge clk) disable iff (!resetn)
    is_ccm_lm |-> (continuity_hw_en && continuity_loss_hw_en && in_lm_nonzero))
    else $error("bad ccm-lm class");
  AST_DMAC: assert property (@(posedge clk) disable iff (!resetn)
    (take && !in_tx && in_dmac != (rx_dest_mac_check_select ? uc_mac : mc_mac))
    |=> ($stable(rx_sel_q) && $stable(rx_non_q)))
    else $error("bad dmac frame counted");
  AST_LEVEL: assert property (@(posedge clk) disable iff (!resetn)
    (take && in_level != maint_level_value) |=> ($stable(rx_sel_q) && $stable(tx_sel_q)))
    else $error("wrong level frame counted");
  AST_CCM_OFF: assert property (@(posedge clk) disable iff (!resetn)
    !continuity_hw_en |-> (word_d[126] == 1'b0 && word_d[127 + SEQ_W] == 1'b0))
    else $error("ccm modified with processing off");
  AST_SHARED: assert property (@(posedge clk) disable iff (!resetn)
    (take && endpoint_enable && per_class_seq_continuity_en && in_tx && valid_oam &&
     class_of_service_id != COS_OWN) |=> $stable(tx_seq_q))
    else $error("own sequence moved for shared class");
endmodule

// ---- pipeline_sink.sv ----
// Far-side model: the pipeline stage that takes result descriptors from the engine.
// Assumes the engine's core clock; stall_pct sets how often it holds off.
`timescale 1ns/10ps
module pipeline_sink (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [6:0] stall_pct,
  output logic out_ready
);
  // Ready is redrawn each cycle, so pops come both back to back and after gaps.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= ($urandom % 100) >= 32'(stall_pct);
    end
  end
endmodule

// ---- tb.sv ----
// Self-checking bench for the OAM endpoint frame engine with a stalling far side.
// Assumes the engine, its FIFO, its package and pipeline_sink are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb
  import oam_endpoint_pkg::*;
;
  typedef struct {logic [1:0] path; logic [47:0] dmac, smac; logic [7:0] op; logic [11:0] sidx;
    logic dp, rwe, loop, ccm, seqw, rdiw, rdi; logic [5:0] port; logic [31:0] seq;} exp_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic endpoint_enable, up_side_select, rx_dest_mac_check_select, block_data_rx, block_data_tx;
  logic loop_drop_prec_clear, loop_egress_rewrite_index_en, continuity_hw_en, continuity_loss_hw_en;
  logic continuity_pdu_count_en, continuity_loss_pdu_count_en, continuity_in_loss_counters_en;
  logic tx_seq_overwrite_en, tx_remote_defect_value, per_class_seq_loopback_en, per_class_seq_continuity_en;
  logic in_valid, in_ready, in_tx, in_is_oam, in_lm_nonzero, in_drop_prec, out_valid, out_ready;
  logic out_drop_prec, out_rewrite_index_en, out_seq_write, out_rdi_write, out_rdi, loss_counter_inc;
  logic [2:0] maint_level_value, in_level, class_of_service_id;
  logic [4:0] loop_en, per_class_counter_set_sel;
  logic [7:0] custom_message, custom_response, in_opcode, out_opcode;
  logic [11:0] loop_service_index, in_service_index, out_service_index;
  logic [47:0] uc_mac, mc_mac, in_dmac, in_smac, out_dmac, out_smac;
  logic [5:0] in_port, home_port, out_port;
  logic [1:0] out_path;
  logic [255:0] pdu_selected;
  logic [31:0] out_seq, rx_drop_count, tx_drop_count, rx_sel_count, rx_nonsel_count, tx_sel_count;
  logic [31:0] tx_nonsel_count, tx_seq_value;
  logic [6:0] stall_pct;
  logic [31:0] m_cnt [6] = '{default: 32'h0000_0000};
  logic [31:0] m_seq = 32'h0000_0000;
  logic [31:0] m_sh [7] = '{default: 32'h0000_0000};
  exp_t q[$];
  exp_t mon_e;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  oam_endpoint_frame_engine dut (.*);
  pipeline_sink sink (.*);

  always #4 clk = ~clk;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Response code for a message that loops, with the hit flag on top.
  function automatic logic [8:0] resp(input logic [7:0] op);
    if (op == 8'h03 && loop_en[0]) return {1'b1, 8'h02};
    if (op == 8'h2B && loop_en[1]) return {1'b1, 8'h2A};
    if (op == 8'h2F && loop_en[2]) return {1'b1, 8'h2E};
    if (op == 8'h37 && loop_en[3]) return {1'b1, 8'h36};
    if (op == custom_message && loop_en[4]) return {1'b1, custom_response};
    return 9'h000;
  endfunction

  // Works out the descriptor the engine must emit for the one just taken, and the counts.
  task automatic predict();
    exp_t e;
    logic ok, ccm, lm, pc;
    e = '{path: 2'h0, dmac: in_dmac, smac: in_smac, op: in_opcode, sidx: in_service_index, dp: in_drop_prec,
      rwe: 1'b0, loop: 1'b0, ccm: 1'b0, seqw: 1'b0, rdiw: 1'b0, rdi: 1'b0, port: in_port, seq: 32'h0};
    ok = in_is_oam && in_level == maint_level_value
      && (in_tx || in_dmac == (rx_dest_mac_check_select ? uc_mac : mc_mac));
    ccm = in_opcode == 8'h01;
    e.ccm = ok && ccm && endpoint_enable;
    if (endpoint_enable && !ok && (in_tx ? block_data_tx : block_data_rx)) begin
      e.path = 2'h3;
      m_cnt[in_tx]++;
    end else if (endpoint_enable && ok) begin
      lm = ccm && continuity_hw_en && continuity_loss_hw_en && in_lm_nonzero;
      if (!ccm || (lm ? continuity_loss_pdu_count_en : continuity_pdu_count_en))
        m_cnt[2 + 2 * in_tx + (pdu_selected[in_opcode] ? 0 : 1)]++;
      if (in_tx && ccm && continuity_hw_en) begin
        pc = per_class_seq_continuity_en && class_of_service_id != 3'h7;
        e.seqw = tx_seq_overwrite_en;
        e.seq = pc ? m_sh[class_of_service_id] : m_seq;
        if (!pc) m_seq++;
        e.rdiw = 1'b1;
        e.rdi = tx_remote_defect_value;
      end
      if (in_tx && (per_class_seq_continuity_en || per_class_seq_loopback_en) && class_of_service_id != 3'h7)
        m_sh[class_of_service_id]++;
      {e.loop, e.op} = in_tx ? {1'b0, in_opcode} : resp(in_opcode);
      if (!e.loop) e.op = in_opcode;
      if (e.loop) begin
        e.dmac = in_smac;
        e.smac = uc_mac;
        e.sidx = loop_service_index;
        e.dp = in_drop_prec & ~loop_drop_prec_clear;
        e.rwe = loop_egress_rewrite_index_en;
        e.path = up_side_select ? 2'h2 : 2'h1;
        e.port = up_side_select ? home_port : in_port;
      end
    end
    q.push_back(e);
  endtask

  // Offers one descriptor and holds it until the edge that takes it.
  task automatic send(input logic tx, input logic oam, input logic [7:0] op, input logic [47:0] dm);
    logic r;
    in_valid <= 1'b1;
    in_tx <= tx;
    in_is_oam <= oam;
    in_opcode <= op;
    in_level <= ($urandom % 6 == 0) ? 3'($urandom) : maint_level_value;
    in_dmac <= dm;
    in_smac <= {16'($urandom), $urandom};
    class_of_service_id <= 3'($urandom);
    in_lm_nonzero <= 1'($urandom);
    in_service_index <= 12'($urandom);
    in_drop_prec <= 1'($urandom);
    in_port <= 6'($urandom);
    do begin
      @(negedge clk);
      r = in_ready;
      @(posedge clk);
    end while (r !== 1'b1);
    predict();
  endtask

  task automatic rand_frame();
    logic [7:0] ops [7] = '{8'h01, 8'h03, 8'h2B, 8'h2F, 8'h37, 8'h2A, 8'h10};
    logic [47:0] good, bad;
    good = rx_dest_mac_check_select ? uc_mac : mc_mac;
    bad = rx_dest_mac_check_select ? mc_mac : uc_mac;
    send(1'($urandom), ($urandom % 5) != 0, ($urandom % 8 == 7) ? custom_message : ops[$urandom % 7],
      (block_data_rx && $urandom % 2 == 1) ? bad : good);
  endtask

  // Random setup; hw selects continuity hardware processing.
  task automatic set_cfg(input logic en, input logic hw);
    endpoint_enable <= en;
    continuity_hw_en <= hw;
    maint_level_value <= 3'($urandom);
    {up_side_select, rx_dest_mac_check_select, block_data_rx, block_data_tx, loop_drop_prec_clear} <= 5'($urandom);
    {loop_egress_rewrite_index_en, continuity_loss_hw_en, continuity_pdu_count_en} <= 3'($urandom);
    {continuity_loss_pdu_count_en, continuity_in_loss_counters_en} <= 2'($urandom);
    {tx_seq_overwrite_en, tx_remote_defect_value} <= 2'($urandom);
    loop_en <= 5'($urandom);
    uc_mac <= {16'($urandom), $urandom};
    mc_mac <= {16'($urandom), $urandom};
    custom_message <= 8'h20 + 8'($urandom % 8);
    custom_response <= 8'($urandom);
    loop_service_index <= 12'($urandom);
    home_port <= 6'($urandom);
    for (int i = 0; i < 8; i++) pdu_selected[i * 32 +: 32] <= $urandom;
  endtask

  // Stops offering, waits for every expected descriptor to pop, and checks the buffer is empty.
  task automatic drain(input int id);
    in_valid <= 1'b0;
    repeat (3000) begin
      @(negedge clk);
      if (q.size() == 0) break;
    end
    `CHK(out_valid, 1'b0)
    `CHK(q.size(), 0)
    $display("test %0d done, %0d left", id, q.size());
  endtask

  task automatic check_counts();
    `CHK(rx_drop_count, m_cnt[0])
    `CHK(tx_drop_count, m_cnt[1])
    `CHK(rx_sel_count, m_cnt[2])
    `CHK(rx_nonsel_count, m_cnt[3])
    `CHK(tx_sel_count, m_cnt[4])
    `CHK(tx_nonsel_count, m_cnt[5])
    `CHK(tx_seq_value, m_seq)
  endtask

  // Compares each popped descriptor with the oldest expectation.
  always @(posedge clk) begin
    if (resetn && out_valid === 1'b1 && out_ready === 1'b1) begin
      `CHK(q.size() > 0, 1'b1)
      mon_e = q.pop_front();
      `CHK(out_path, mon_e.path)
      if (mon_e.path != 2'h3) begin
        `CHK(out_opcode, mon_e.op)
        `CHK(out_dmac, mon_e.dmac)
        `CHK(out_smac, mon_e.smac)
        `CHK(out_port, mon_e.port)
        `CHK(out_service_index, mon_e.sidx)
        `CHK(out_drop_prec, mon_e.dp)
        `CHK(out_seq_write, mon_e.seqw)
        `CHK(out_rdi_write, mon_e.rdiw)
      end
      `CHK(out_rewrite_index_en, mon_e.rwe)
      if (mon_e.seqw) `CHK(out_seq, mon_e.seq)
      if (mon_e.rdiw) `CHK(out_rdi, mon_e.rdi)
      `CHK(loss_counter_inc, mon_e.ccm && continuity_in_loss_counters_en)
    end
  end

  // Cuts a hang short well above the length of the whole sequence.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'hA8D6C3BE));
    in_valid = 1'b0;
    stall_pct = 7'h00;
    {in_tx, in_is_oam, in_opcode, in_level, in_dmac, in_smac, class_of_service_id} = '0;
    {in_lm_nonzero, in_service_index, in_drop_prec, in_port} = '0;
    // Per-class numbering starts off; only its continuity enable is ever set, in the last test.
    per_class_seq_loopback_en = 1'b0;
    per_class_seq_continuity_en = 1'b0;
    per_class_counter_set_sel = 5'h00;
    set_cfg(1'b1, 1'b1);
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    `CHK(in_ready, 1'b1)
    check_counts();
    // Random traffic, far side from prompt to slow.
    for (int t = 0; t < 6; t++) begin
      @(posedge clk);
      set_cfg(1'b1, 1'b1);
      stall_pct <= 7'(t * 15);
      @(posedge clk);
      repeat (40) rand_frame();
      drain(t);
      check_counts();
    end
    // Fill the buffer with the far side stalled until it refuses, then drain it.
    @(posedge clk);
    stall_pct <= 7'd100;
    repeat (3) @(posedge clk);
    repeat (16) rand_frame();
    in_valid <= 1'b0;
    @(negedge clk);
    `CHK(in_ready, 1'b0)
    @(posedge clk);
    stall_pct <= 7'd0;
    drain(6);
    check_counts();
    // Disabled endpoint with blocking and every loop on: all frames pass untouched, no counts.
    @(posedge clk);
    set_cfg(1'b0, 1'b1);
    @(posedge clk);
    {block_data_rx, block_data_tx} <= 2'b11;
    loop_en <= 5'h1F;
    @(posedge clk);
    repeat (30) rand_frame();
    drain(7);
    check_counts();
    // Continuity processing off: transmitted CCMs carry no sequence or defect rewrite.
    @(posedge clk);
    set_cfg(1'b1, 1'b0);
    @(posedge clk);
    repeat (10) send(1'b1, 1'b1, 8'h01, uc_mac);
    drain(8);
    check_counts();
    // Per-class continuity numbering on one counter set; class 7 keeps the endpoint's own word.
    @(posedge clk);
    set_cfg(1'b1, 1'b1);
    per_class_seq_continuity_en <= 1'b1;
    per_class_counter_set_sel <= 5'h0B;
    @(posedge clk);
    tx_seq_overwrite_en <= 1'b1;
    @(posedge clk);
    repeat (40) send(1'b1, 1'b1, ($urandom % 2 == 1) ? 8'h01 : 8'h03, uc_mac);
    drain(9);
    check_counts();
    give_verdict();
  end
endmodule
